// [verilog/clkctl_pkg.sv]
// clkctl_pkg: constants, configuration layout and types of the clock network block
// assumes one 250 MHz system clock; every modelled clock is a level sampled on it
package clkctl_pkg;
    localparam int CLK_MHZ       = 250;
    localparam int LOCK_T_US     = 150;
    localparam int LOCK_CYC      = LOCK_T_US * CLK_MHZ;
    localparam int OSC_KHZ       = 22000;
    localparam int OSC_HALF_CYC  = (CLK_MHZ * 1000) / (2 * OSC_KHZ);
    localparam int NPRI          = 4;
    localparam int NSEC          = 4;
    localparam int NPIN          = 4;
    localparam int NROUTE        = 12;
    localparam int NSRC          = 16;
    localparam int SEL_W         = 4;
    localparam int DIV_W         = 8;
    localparam int DLY_W         = 4;
    localparam int DLY_TAPS      = 16;
    localparam int PER_W         = 16;
    localparam int LOCK_W        = 16;
    localparam int PH_W          = 8;
    localparam int OSC_W         = 4;
    // source index layout of the large variant primary nets and of the tree oscillator on secondary nets
    localparam int NROUTE_LG     = 9;
    localparam int IDX_ROUTE     = 4;
    localparam int IDX_PLL_OK    = 13;
    localparam int IDX_PLL_OS    = 14;
    localparam int IDX_PLL_OP    = 15;
    localparam int IDX_SEC_OSC   = 15;
    localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(OSC_HALF_CYC - 1);

    typedef enum logic [1:0] {
        FB_INTERNAL = 2'b00,
        FB_GLOBAL   = 2'b01,
        FB_POST     = 2'b10,
        FB_EXT      = 2'b11
    } clkctl_fbsrc_t;

    typedef enum logic [1:0] {
        LK_RESET  = 2'b00,
        LK_ACQ    = 2'b01,
        LK_LOCKED = 2'b10
    } clkctl_lock_t;

    // divider fields hold ratio minus one
    typedef struct packed {
        logic                    large_variant;
        logic [NPRI*SEL_W-1:0]   pri_sel;
        logic [NSEC*SEL_W-1:0]   sec_sel;
        logic                    ref_from_route;
        logic [DIV_W-1:0]        in_div;
        logic [DIV_W-1:0]        fb_div;
        logic [DIV_W-1:0]        post_div;
        logic [DIV_W-1:0]        sec_div;
        logic [DIV_W-1:0]        osc_div;
        clkctl_fbsrc_t           fb_src;
        logic                    dly_in_feedback;
        logic                    dly_dynamic;
        logic [DLY_W-1:0]        dly_static;
        logic [PH_W-1:0]         phase;
        logic [PH_W-1:0]         duty;
        logic                    osc_en;
        logic                    osc_to_tree;
    } clkctl_cfg_t;

    typedef struct packed {
        logic op;
        logic os;
        logic ok;
        logic lock;
    } clkctl_pll_t;
endpackage : clkctl_pkg

// [verilog/clkctl_div.sv]
// clkctl_div: counts rising edges of a sampled clock level and divides by ratio+1
// assumes src is a level synchronous to mclk; ratio is held static
`timescale 1ns/100ps
`default_nettype none
module clkctl_div
    import clkctl_pkg::*;
(
    input  wire logic                         mclk,
    input  wire logic                         rst,
    input  wire logic                         src,
    input  wire logic [clkctl_pkg::DIV_W-1:0] ratio,
    output logic                              lvl_r,
    output logic                              tick_r
);
    import clkctl_pkg::*;

    logic             src_d_r;
    logic [DIV_W-1:0] cnt_r;
    logic [DIV_W-1:0] cnt_nxt;
    logic             rise;
    logic             wrap;

    // edge and wrap decode
    assign rise    = src & ~src_d_r;
    assign wrap    = rise && (cnt_r == ratio);
    assign cnt_nxt = wrap ? '0 : (rise ? cnt_r + 1'b1 : cnt_r);

    // count; divide by one passes the level straight through
    always_ff @(posedge mclk) begin
        if (rst) begin
            src_d_r <= 1'b0;
            cnt_r   <= '0;
            lvl_r   <= 1'b0;
            tick_r  <= 1'b0;
        end else begin
            src_d_r <= src;
            cnt_r   <= cnt_nxt;
            lvl_r   <= (ratio == '0) ? src : (cnt_nxt <= (ratio >> 1));
            tick_r  <= wrap;
        end
    end
endmodule : clkctl_div
`default_nettype wire

// [verilog/clkctl_top.sv]
// clkctl_top: global clock selection, PLL behaviour model and internal oscillator
// assumes all clock pins and routing inputs are levels synchronous to mclk and
// that configuration is stable while rst is high, where it is captured
`timescale 1ns/100ps
`default_nettype none
module clkctl_top
    import clkctl_pkg::*;
#(
    parameter logic [LOCK_W-1:0] T_LOCK_CYC = LOCK_W'(clkctl_pkg::LOCK_CYC)
)(
    input  wire logic                          mclk,
    input  wire logic                          rst,
    input  wire clkctl_pkg::clkctl_cfg_t       cfg,
    input  wire logic [clkctl_pkg::NPIN-1:0]   clk_pin,
    input  wire logic [clkctl_pkg::NROUTE-1:0] route_sig,
    input  wire logic                          ref_pin,
    input  wire logic                          ref_route,
    input  wire logic                          fb_ext,
    input  wire logic                          pll_rst,
    input  wire logic                          dly_load,
    input  wire logic [clkctl_pkg::DLY_W-1:0]  dly_value,
    output logic [clkctl_pkg::NPRI-1:0]        gclk_pri,
    output logic [clkctl_pkg::NSEC-1:0]        gclk_sec,
    output clkctl_pkg::clkctl_pll_t            pll,
    output logic                               osc_clk,
    output logic                               osc_route,
    output logic                               osc_slow
);
    import clkctl_pkg::*;

    // 16:1 selection, shared by every primary and secondary net
    function automatic logic pick16(input logic [NSRC-1:0] src, input logic [SEL_W-1:0] sel);
        pick16 = src[sel];
    endfunction : pick16

    clkctl_cfg_t           cfg_r;
    logic [NPRI-1:0]       gclk_pri_r;
    logic [NSEC-1:0]       gclk_sec_r;
    clkctl_pll_t           pll_r;
    logic                  osc_clk_r;
    logic                  osc_route_r;
    logic [OSC_W-1:0]      osc_cnt_r;
    logic [DLY_W-1:0]      dly_r;
    logic                  dly_chg_r;
    logic [DLY_TAPS-1:0]   dly_sr_r;
    logic [PER_W-1:0]      per_cnt_r;
    logic [PER_W-1:0]      per_r;
    logic [PER_W-1:0]      acc_r;
    logic                  vco_r;
    logic                  vco_d_r;
    logic [PH_W-1:0]       ph_cnt_r;
    logic [1:0]            fb_seen_r;
    logic [LOCK_W-1:0]     lock_cnt_r;
    clkctl_lock_t          lk_r;
    clkctl_lock_t          lk_nxt;

    logic [NSRC-1:0]       pri_src;
    logic [NSRC-1:0]       sec_src;
    logic                  tree_osc;
    logic                  ref_lvl;
    logic                  fb_raw;
    logic                  dly_in;
    logic                  dly_tap;
    logic                  ref_to_div;
    logic                  fb_to_div;
    logic                  pfd_tick;
    logic                  fb_tick;
    logic                  post_lvl;
    logic                  post_tick;
    logic                  sec_lvl;
    logic                  osc_div_lvl;
    logic [PER_W-1:0]      nco_step;
    logic [PER_W:0]        acc_sum;
    logic                  vco_tick;
    logic                  vco_rise;
    logic                  fb_match;
    logic                  lock_restart;
    logic [PH_W:0]         ph_end;
    logic                  os_nxt;

    // source sets: pins + twelve routes; large swaps primary routes 9-11 for PLL outputs, osc_to_tree swaps secondary route 11
    assign tree_osc = cfg_r.osc_to_tree ? osc_clk_r : route_sig[NROUTE-1];
    assign pri_src  = cfg_r.large_variant
                    ? {pll_r.op, pll_r.os, pll_r.ok,
                       route_sig[NROUTE_LG-1:0], clk_pin}
                    : {route_sig, clk_pin};
    assign sec_src  = {tree_osc, route_sig[NROUTE-2:0], clk_pin};

    // reference select and programmable delay placement
    assign ref_lvl    = cfg_r.ref_from_route ? ref_route : ref_pin;
    assign dly_in     = cfg_r.dly_in_feedback ? fb_raw : ref_lvl;
    assign dly_tap    = dly_sr_r[dly_r];
    assign ref_to_div = cfg_r.dly_in_feedback ? ref_lvl : dly_tap;
    assign fb_to_div  = cfg_r.dly_in_feedback ? dly_tap : fb_raw;

    // feedback source select
    assign fb_raw = (cfg_r.fb_src == FB_INTERNAL) ? vco_r      :
                    (cfg_r.fb_src == FB_GLOBAL)   ? gclk_pri_r[0] :
                    (cfg_r.fb_src == FB_POST)     ? post_lvl   : fb_ext;

    // core model: toggles 2*(fb_div+1) times per divided reference period
    assign nco_step = PER_W'({1'b0, cfg_r.fb_div} + 1'b1) << 1;
    assign acc_sum  = {1'b0, acc_r} + {1'b0, nco_step};
    assign vco_tick = (per_r != '0) && (acc_sum >= {1'b0, per_r});
    assign vco_rise = vco_r & ~vco_d_r;

    // lock check: exactly one feedback tick per reference tick
    assign fb_match     = (fb_seen_r + {1'b0, fb_tick}) == 2'b01;
    assign lock_restart = dly_chg_r || (pfd_tick && !fb_match);

    // secondary output window within one post-scaler period
    assign ph_end = {1'b0, cfg_r.phase} + {1'b0, cfg_r.duty} + 1'b1;
    assign os_nxt = ({1'b0, ph_cnt_r} >= {1'b0, cfg_r.phase})
                 && ({1'b0, ph_cnt_r} < ph_end);

    // the four dividers of the PLL and the oscillator divider
    clkctl_div u_in_div (
        .mclk   (mclk),
        .rst    (rst),
        .src    (ref_to_div),
        .ratio  (cfg_r.in_div),
        .lvl_r  (),
        .tick_r (pfd_tick)
    );
    clkctl_div u_fb_div (
        .mclk   (mclk),
        .rst    (rst),
        .src    (fb_to_div),
        .ratio  (cfg_r.fb_div),
        .lvl_r  (),
        .tick_r (fb_tick)
    );
    clkctl_div u_post_div (
        .mclk   (mclk),
        .rst    (rst),
        .src    (vco_r),
        .ratio  (cfg_r.post_div),
        .lvl_r  (post_lvl),
        .tick_r (post_tick)
    );
    clkctl_div u_sec_div (
        .mclk   (mclk),
        .rst    (rst),
        .src    (post_lvl),
        .ratio  (cfg_r.sec_div),
        .lvl_r  (sec_lvl),
        .tick_r ()
    );
    clkctl_div u_osc_div (
        .mclk   (mclk),
        .rst    (rst),
        .src    (osc_clk_r),
        .ratio  (cfg_r.osc_div),
        .lvl_r  (osc_div_lvl),
        .tick_r ()
    );

    // configuration captured only during reset, frozen afterwards
    always_ff @(posedge mclk) begin
        if (rst) begin
            cfg_r <= cfg;
        end
    end

    // global nets, one registered selector per net
    genvar g;
    generate
        for (g = 0; g < NPRI; g++) begin : g_pri
            always_ff @(posedge mclk) begin
                if (rst) begin
                    gclk_pri_r[g] <= 1'b0;
                end else begin
                    gclk_pri_r[g] <= pick16(pri_src, cfg_r.pri_sel[g*SEL_W +: SEL_W]);
                end
            end
        end
        for (g = 0; g < NSEC; g++) begin : g_sec
            always_ff @(posedge mclk) begin
                if (rst) begin
                    gclk_sec_r[g] <= 1'b0;
                end else begin
                    gclk_sec_r[g] <= pick16(sec_src, cfg_r.sec_sel[g*SEL_W +: SEL_W]);
                end
            end
        end
    endgenerate

    // delay value: static from configuration, reloaded live in dynamic mode
    always_ff @(posedge mclk) begin
        if (rst) begin
            dly_r     <= cfg.dly_static;
            dly_chg_r <= 1'b0;
        end else begin
            dly_chg_r <= 1'b0;
            if (cfg_r.dly_dynamic && dly_load) begin
                dly_r     <= dly_value;
                dly_chg_r <= (dly_value != dly_r);
            end
        end
    end

    // delay line shifted every cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            dly_sr_r <= '0;
        end else begin
            dly_sr_r <= {dly_sr_r[DLY_TAPS-2:0], dly_in};
        end
    end

    // reference period measured between input divider ticks
    always_ff @(posedge mclk) begin
        if (rst || pll_rst) begin
            per_cnt_r <= '0;
            per_r     <= '0;
        end else if (pfd_tick) begin
            per_cnt_r <= PER_W'(1);
            per_r     <= per_cnt_r;
        end else if (per_cnt_r != '1) begin
            per_cnt_r <= per_cnt_r + 1'b1;
        end
    end

    // oscillator core
    always_ff @(posedge mclk) begin
        if (rst || pll_rst) begin
            acc_r   <= '0;
            vco_r   <= 1'b0;
            vco_d_r <= 1'b0;
        end else begin
            acc_r   <= vco_tick ? PER_W'(acc_sum - {1'b0, per_r}) : acc_sum[PER_W-1:0];
            vco_r   <= vco_r ^ vco_tick;
            vco_d_r <= vco_r;
        end
    end

    // core edges counted from each post-scaler wrap for phase placement
    always_ff @(posedge mclk) begin
        if (rst || post_tick) begin
            ph_cnt_r <= '0;
        end else if (vco_rise && ph_cnt_r != '1) begin
            ph_cnt_r <= ph_cnt_r + 1'b1;
        end
    end

    // feedback ticks seen since the last reference tick
    always_ff @(posedge mclk) begin
        if (rst || pfd_tick) begin
            fb_seen_r <= '0;
        end else if (fb_tick && fb_seen_r != 2'b11) begin
            fb_seen_r <= fb_seen_r + 1'b1;
        end
    end

    // lock sequencer next state
    always_comb begin
        lk_nxt = lk_r;
        case (lk_r)
            LK_RESET: begin
                lk_nxt = LK_ACQ;
            end
            LK_ACQ: begin
                if (!lock_restart && lock_cnt_r == T_LOCK_CYC) begin
                    lk_nxt = LK_LOCKED;
                end
            end
            LK_LOCKED: begin
                if (lock_restart) begin
                    lk_nxt = LK_ACQ;
                end
            end
            default: begin
                lk_nxt = LK_RESET;
            end
        endcase
        if (pll_rst) begin
            lk_nxt = LK_RESET;
        end
    end

    // lock state and lock-in timer
    always_ff @(posedge mclk) begin
        if (rst) begin
            lk_r       <= LK_RESET;
            lock_cnt_r <= '0;
        end else begin
            lk_r <= lk_nxt;
            if (lk_nxt != LK_ACQ || lock_restart || per_r == '0) begin
                lock_cnt_r <= '0;
            end else if (lock_cnt_r != T_LOCK_CYC) begin
                lock_cnt_r <= lock_cnt_r + 1'b1;
            end
        end
    end

    // PLL outputs
    always_ff @(posedge mclk) begin
        if (rst) begin
            pll_r <= '0;
        end else begin
            pll_r.op   <= post_lvl;
            pll_r.os   <= os_nxt;
            pll_r.ok   <= sec_lvl;
            pll_r.lock <= (lk_nxt == LK_LOCKED);
        end
    end

    // internal oscillator, silent while disabled
    always_ff @(posedge mclk) begin
        if (rst || !cfg_r.osc_en) begin
            osc_cnt_r <= '0;
            osc_clk_r <= 1'b0;
        end else if (osc_cnt_r == OSC_LAST) begin
            osc_cnt_r <= '0;
            osc_clk_r <= ~osc_clk_r;
        end else begin
            osc_cnt_r <= osc_cnt_r + 1'b1;
        end
    end

    // oscillator onto general routing when not given to the tree
    always_ff @(posedge mclk) begin
        if (rst) begin
            osc_route_r <= 1'b0;
            osc_slow    <= 1'b0;
        end else begin
            osc_route_r <= osc_clk_r & ~cfg_r.osc_to_tree;
            osc_slow    <= osc_div_lvl;
        end
    end

    assign gclk_pri  = gclk_pri_r;
    assign gclk_sec  = gclk_sec_r;
    assign pll       = pll_r;
    assign osc_clk   = osc_clk_r;
    assign osc_route = osc_route_r;

    AST_LOCK_IN_RST: assert property (@(posedge mclk) disable iff (rst)
        pll_rst |=> !pll_r.lock)
        else $error("lock high during PLL reset");

    AST_LOCK_DROP_DLY: assert property (@(posedge mclk) disable iff (rst)
        dly_chg_r |=> !pll_r.lock [*2])
        else $error("lock held after delay change");

    AST_LOCK_AFTER_TIME: assert property (@(posedge mclk) disable iff (rst)
        $rose(pll_r.lock) |-> $past(lock_cnt_r) == T_LOCK_CYC)
        else $error("lock rose before lock-in time");

    AST_OSC_OFF: assert property (@(posedge mclk) disable iff (rst)
        !cfg_r.osc_en |=> !osc_clk_r)
        else $error("oscillator toggles while disabled");

    AST_OSC_HALF: assert property (@(posedge mclk) disable iff (rst || !cfg_r.osc_en)
        $rose(osc_clk_r) |-> osc_clk_r [*5] ##1 !osc_clk_r)
        else $error("oscillator half period wrong");

    AST_PRI_SMALL: assert property (@(posedge mclk) disable iff (rst)
        (!cfg_r.large_variant && cfg_r.pri_sel[2*SEL_W +: SEL_W] == SEL_W'(IDX_ROUTE))
        |=> gclk_pri[2] == $past(route_sig[0]))
        else $error("primary net 2 not routing 0");

    AST_PRI_LARGE_PLL: assert property (@(posedge mclk) disable iff (rst)
        (cfg_r.large_variant && cfg_r.pri_sel[3*SEL_W +: SEL_W] == SEL_W'(IDX_PLL_OP))
        |=> gclk_pri[3] == $past(pll_r.op))
        else $error("primary net 3 not PLL primary output");

    AST_DLY_DYN: assert property (@(posedge mclk) disable iff (rst)
        (cfg_r.dly_dynamic && dly_load) |=> dly_r == $past(dly_value))
        else $error("dynamic delay not loaded");

    AST_DLY_STATIC: assert property (@(posedge mclk) disable iff (rst)
        !cfg_r.dly_dynamic |=> $stable(dly_r) && $stable(cfg_r))
        else $error("static setting changed while running");

    AST_OSC_ROUTE: assert property (@(posedge mclk) disable iff (rst)
        cfg_r.osc_to_tree |=> !osc_route)
        else $error("oscillator on routing while given to tree");
endmodule : clkctl_top
`default_nettype wire

// [tb/tb_clkctl_top.sv]
// tb_clkctl_top: self-checking bench for the clock network block
// assumes clkctl_pkg and clkctl_top compiled first; lock time cut to 64 cycles
`timescale 1ns/100ps
`default_nettype none
module tb_clkctl_top;
    import clkctl_pkg::*;
    localparam int TL = 64;
    // mux table: pins, routing, expected primary nets, expected secondary nets
    localparam logic [23:0] MUXTAB [6] = '{24'h100010, 24'h800020, 24'h200001,
                                           24'h000142, 24'h040004, 24'h080088};
    logic        mclk, rst, ref_pin, pll_rst, dly_load, osc_clk, osc_route, osc_slow;
    logic        ref_wave, ref_swap, ref_route, fb_ext;
    logic [3:0]  clk_pin, dly_value, gclk_pri, gclk_sec;
    logic [11:0] route_sig;
    clkctl_cfg_t cfg;
    clkctl_pll_t pll;
    int          fails, num_checks;

    clkctl_top #(.T_LOCK_CYC(16'h0040)) u_dut (
        .mclk(mclk), .rst(rst), .cfg(cfg), .clk_pin(clk_pin), .route_sig(route_sig),
        .ref_pin(ref_pin), .ref_route(ref_route), .fb_ext(fb_ext), .pll_rst(pll_rst),
        .dly_load(dly_load), .dly_value(dly_value), .gclk_pri(gclk_pri),
        .gclk_sec(gclk_sec), .pll(pll), .osc_clk(osc_clk), .osc_route(osc_route),
        .osc_slow(osc_slow));

    // system clock and a 20-cycle reference clock
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // reference is 12.5 MHz, so fb_div 0 keeps the output within four times it
    initial begin
        ref_wave = 1'b0;
        forever begin
            repeat (10) @(posedge mclk);
            #1 ref_wave = ~ref_wave;
        end
    end

    // reference steered to pin or routing; external feedback loops the primary output back
    assign ref_pin   = ref_wave & ~ref_swap;
    assign ref_route = ref_wave & ref_swap;
    assign fb_ext    = pll.op;

    task automatic check(input bit ok, input string m);
        num_checks++;
        if (!ok) begin
            fails++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc

    // capture a configuration under reset; outputs must sit low meanwhile
    task automatic restart(input clkctl_cfg_t c);
        cfg = c;
        rst = 1'b1;
        cyc(5);
        check(gclk_pri === 4'h0 && gclk_sec === 4'h0 && pll === 4'h0, "reset");
        rst = 1'b0;
    endtask : restart

    task automatic wait_lock(output int n);
        n = 0;
        while (pll.lock !== 1'b1 && n < 3000) begin
            cyc(1);
            n++;
        end
    endtask : wait_lock

    // counts toggles of the oscillator outputs and of secondary net 3
    task automatic count(input int len, output int f, output int s, output int r, output int g);
        logic pf, ps, pr, pg;
        f = 0;
        s = 0;
        r = 0;
        g = 0;
        for (int i = 0; i < len; i++) begin
            {pf, ps, pr, pg} = {osc_clk, osc_slow, osc_route, gclk_sec[3]};
            cyc(1);
            f += int'(osc_clk !== pf);
            s += int'(osc_slow !== ps);
            r += int'(osc_route !== pr);
            g += int'(gclk_sec[3] !== pg);
        end
    endtask : count

    task automatic t_mux;
        clkctl_cfg_t c;
        c = '0;
        c.pri_sel = 16'hF430;
        c.sec_sel = 16'hFE41;
        restart(c);
        for (int i = 0; i < 6; i++) begin
            {clk_pin, route_sig} = MUXTAB[i][23:8];
            cyc(1);
            check(gclk_pri === MUXTAB[i][7:4] && gclk_sec === MUXTAB[i][3:0], "mux");
        end
        c.large_variant = 1'b1;
        c.pri_sel = 16'hFDC4;
        {clk_pin, route_sig} = 16'h0000;
        restart(c);
        cfg.pri_sel = 16'h0000;
        route_sig = 12'h300;
        cyc(1);
        check(gclk_pri === 4'h2, "large mux or live cfg change");
        route_sig = 12'h000;
    endtask : t_mux

    task automatic t_osc;
        clkctl_cfg_t c;
        int n, f, s, r, g;
        c = '0;
        c.osc_en = 1'b1;
        c.osc_div = 8'h01;
        restart(c);
        n = 0;
        while (osc_clk !== 1'b1 && n < 20) begin
            cyc(1);
            n++;
        end
        n = 0;
        while (osc_clk === 1'b1 && n < 20) begin
            cyc(1);
            n++;
        end
        check(n == OSC_HALF_CYC, "osc half period");
        count(200, f, s, r, g);
        check(f > 0 && r == f, "osc to routing");
        check(s * 2 >= f - 2 && s * 2 <= f + 2, "osc divide");
        c.osc_to_tree = 1'b1;
        c.sec_sel = 16'hF000;
        restart(c);
        count(100, f, s, r, g);
        check(f > 0 && r == 0 && g >= f - 1 && g <= f + 1, "osc to tree");
        c.osc_en = 1'b0;
        restart(c);
        count(100, f, s, r, g);
        check(f == 0 && osc_clk === 1'b0, "osc disabled");
    endtask : t_osc

    task automatic t_pll;
        clkctl_cfg_t c;
        int n, f, s, r, g, k;
        c = '0;
        c.dly_static = 4'h3;
        restart(c);
        wait_lock(n);
        check(pll.lock === 1'b1 && n >= TL, "lock time");
        pll_rst = 1'b1;
        cyc(2);
        check(pll.lock === 1'b0, "lock in pll reset");
        pll_rst = 1'b0;
        wait_lock(n);
        check(pll.lock === 1'b1 && n >= TL, "relock after pll reset");
        {dly_value, dly_load} = 5'h13;
        cyc(1);
        dly_load = 1'b0;
        k = 0;
        f = 0;
        s = 0;
        r = 0;
        for (int i = 0; i < 80; i++) begin
            g = int'({pll.op, pll.os, pll.ok});
            cyc(1);
            k += int'(pll.lock !== 1'b1);
            f += int'(pll.op !== g[2]);
            s += int'(pll.os !== g[1]);
            r += int'(pll.ok !== g[0]);
        end
        check(k == 0, "static load refused");
        check(f > 0 && s > 0 && r > 0, "pll outputs run");
        c.dly_dynamic = 1'b1;
        c.dly_in_feedback = 1'b1;
        restart(c);
        wait_lock(n);
        check(pll.lock === 1'b1, "lock with delay in feedback path");
        {dly_value, dly_load} = 5'h13;
        cyc(1);
        dly_load = 1'b0;
        cyc(2);
        check(pll.lock === 1'b0, "lock drop");
        wait_lock(n);
        check(pll.lock === 1'b1 && n >= TL - 2, "relock");
    endtask : t_pll

    // routed reference and the post-scaler and external feedback sources
    task automatic t_src;
        clkctl_cfg_t c;
        int n;
        c = '0;
        c.ref_from_route = 1'b1;
        c.fb_src = FB_POST;
        restart(c);
        wait_lock(n);
        check(pll.lock === 1'b0, "lock without routed reference");
        ref_swap = 1'b1;
        restart(c);
        wait_lock(n);
        check(pll.lock === 1'b1, "routed reference, post-scaler feedback");
        c.fb_src = FB_EXT;
        restart(c);
        wait_lock(n);
        check(pll.lock === 1'b1, "external feedback");
        ref_swap = 1'b0;
    endtask : t_src

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test

    // watchdog well beyond the expected run
    initial begin
        #(40000 * 4);
        fails++;
        end_of_test();
    end

    initial begin
        {pll_rst, dly_load, dly_value, clk_pin, route_sig, ref_swap} = '0;
        fails = 0;
        num_checks = 0;
        t_mux();
        t_osc();
        t_pll();
        t_src();
        end_of_test();
    end
endmodule : tb_clkctl_top
`default_nettype wire
